// ==== logic/rst_seq_pkg.sv ====
// Constants for the reset sequencer and interrupt entry block
package rst_seq_pkg;
  localparam int unsigned CLOCK_HZ        = 40_000_000;
  localparam int unsigned OSC_STAB_CYCLES = 4096;
  localparam int unsigned PIN_DRIVE_CYC   = 32;
  localparam int unsigned CORE_HOLD_CYC   = 32;
  localparam int unsigned PIN_SAMPLE_CYC  = 32;
  localparam int unsigned POR_CPU_CYC     = 64;
  localparam int unsigned MIN_PULSE_NS    = 100;
  localparam int unsigned MIN_PULSE_CYC   =
    (MIN_PULSE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [15:0] RESET_VECTOR    = 16'hFFFE;
  localparam logic [15:0] SWI_VECTOR      = 16'hFFFC;
  localparam logic [15:0] IRQ_VECTOR_TOP  = 16'hFFFA;
  localparam logic [1:0]  BUS_DIV         = 2'h2;
  // Register offsets, reset cause and control bits, watchdog width
  localparam logic [11:0] CAUSE_OFFSET    = 12'h000;
  localparam logic [11:0] STATUS_OFFSET   = 12'h004;
  localparam logic [11:0] CONTROL_OFFSET  = 12'h008;
  localparam int unsigned LOW_SUPPLY_BIT  = 1;
  localparam int unsigned MONITOR_BIT     = 2;
  localparam int unsigned ILL_ADDR_BIT    = 3;
  localparam int unsigned ILL_OP_BIT      = 4;
  localparam int unsigned WATCHDOG_BIT    = 5;
  localparam int unsigned EXT_PIN_BIT     = 6;
  localparam int unsigned POWER_ON_BIT    = 7;
  localparam logic [7:0]  CAUSE_RESET     = 8'h80;
  localparam int unsigned CTRL_STOP_EN    = 0;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam int unsigned WDOG_WIDTH      = 18;
endpackage

// ==== logic/irq_arbiter.sv ====
// Fixed-priority selector for pending interrupt requests
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter #(
  parameter int unsigned N = 16
) (
  input  wire logic [N-1:0] pending,
  output logic              any_pending,
  output logic [4:0]        winner
);
  logic [4:0] pick;

  always_comb begin
    pick = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pick = 5'(i);
      end
    end
  end

  assign any_pending = |pending;
  assign winner      = pick;
endmodule
`default_nettype wire

// ==== logic/reset_sequencer_and_irq_entry.sv ====
// Reset sequencing, reset cause flags and interrupt entry control
//
// What this block does
// - Reset aborts instruction, fetches vector FFFE-FFFF
// - Every reset selects oscillator clock divide-by-four
// - Low reset pin for minimum time resets
// - Internal reset drives pin 32, holds 32
// - Power-on: 4096 gated, pin +32, CPU +32
// - Power-on sets own flag, clears others
// - Low supply holds pin, then power-on timing
// - Watchdog overflow resets; write at FFFF clears
// - Undefined opcode, or disabled stop, resets
// - Unmapped opcode fetch resets; data access not
// - Monitor entry reset sets its flag
// - Cause register read-only, cleared by read
// - Flags accumulate until read
// - Pin sampled 32 after release; low sets flag
// - Interrupts wait for instruction end
// - Entry stacks registers, masks, loads vector
// - Latched interrupt is never preempted
// - Boundary with mask clear picks highest priority
// - Pending request served right after return
// - High index byte is not stacked
// - Global mask blocks all but software interrupt
// - Falling edge on external interrupt pin latches request
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_and_irq_entry #(
  parameter int unsigned STAB_CYCLES = rst_seq_pkg::OSC_STAB_CYCLES,
  parameter int unsigned WDOG_W      = rst_seq_pkg::WDOG_WIDTH,
  parameter int unsigned N_IRQ       = 16
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             reset_pin_in,
  output logic                  reset_pin_out,
  output logic                  reset_pin_oe_n,
  input  wire logic             supply_low,
  input  wire logic             monitor_entry,
  input  wire logic             opcode_fetch,
  input  wire logic [15:0]      fetch_addr,
  input  wire logic             fetch_unmapped,
  input  wire logic             opcode_undefined,
  input  wire logic             opcode_stop,
  input  wire logic             wdog_write,
  input  wire logic             insn_done,
  input  wire logic             swi_request,
  input  wire logic             rti_done,
  input  wire logic             external_interrupt_pin,
  input  wire logic [N_IRQ-1:0] irq_requests,
  output logic                  core_reset,
  output logic                  clocks_gated,
  output logic [1:0]            bus_clock_div,
  output logic                  vector_fetch,
  output logic [15:0]           vector_addr,
  output logic                  stack_push,
  output logic                  stack_pop,
  output logic                  irq_mask,
  output logic                  irq_ack
);
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_STAB   = 3'b001,
    ST_DRIVE  = 3'b010,
    ST_HOLD   = 3'b011,
    ST_LOWSUP = 3'b100
  } seq_e;

  seq_e        state_reg, state_next;
  logic [12:0] count_reg, count_next;
  logic [7:0]  cause_reg, cause_next;
  logic [7:0]  control_reg;
  logic [5:0]  sample_reg;
  logic [7:0]  pulse_reg;
  logic [WDOG_W-1:0] wdog_reg;
  logic        ext_irq_reg;
  logic        latched_reg;
  logic [15:0] latched_vec_reg;
  logic        prev_pin_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        pin_drive_reg;
  logic        core_reset_reg;
  logic        gated_reg;
  logic        vfetch_reg;
  logic [15:0] vaddr_reg;
  logic        push_reg;
  logic        pop_reg;
  logic        mask_reg;
  logic        ack_reg;

  // APB decode: zero-wait access phase answer
  wire access     = psel & penable;
  wire rd_access  = access & ~pwrite;
  wire wr_access  = access & pwrite;
  wire hit_cause  = paddr == rst_seq_pkg::CAUSE_OFFSET;
  wire hit_status = paddr == rst_seq_pkg::STATUS_OFFSET;
  wire hit_ctrl   = paddr == rst_seq_pkg::CONTROL_OFFSET;
  wire mapped     = hit_cause | hit_status | hit_ctrl;
  wire cause_read = rd_access & hit_cause;
  wire ctrl_write = wr_access & hit_ctrl;
  wire bad_access = access & (~mapped | (pwrite & ~hit_ctrl));
  wire [31:0] status_word = {24'h00_0000, 3'h0, latched_reg, mask_reg,
                             gated_reg, core_reset_reg, pin_drive_reg};
  wire [31:0] rd_mux = hit_cause  ? {24'h00_0000, cause_reg} :
                       hit_status ? status_word :
                       hit_ctrl   ? {24'h00_0000, control_reg} :
                                    32'h0000_0000;

  // Reset causes
  wire stop_enabled = control_reg[rst_seq_pkg::CTRL_STOP_EN];
  wire running      = state_reg == ST_RUN;
  wire wdog_ovf     = running & (&wdog_reg);
  wire ill_op  = running & opcode_fetch &
                 (opcode_undefined | (opcode_stop & ~stop_enabled));
  wire ill_ad  = running & opcode_fetch & fetch_unmapped;
  wire mon_rst = running & monitor_entry;
  wire ext_rst = running & (pulse_reg >= 8'(rst_seq_pkg::MIN_PULSE_CYC));
  wire internal_rst = wdog_ovf | ill_op | ill_ad | mon_rst;
  wire pin_released = (state_reg == ST_DRIVE) &&
                      (count_reg == 13'(rst_seq_pkg::PIN_DRIVE_CYC - 1));
  wire sample_due   = sample_reg == 6'(rst_seq_pkg::PIN_SAMPLE_CYC);
  wire late_pin_low = sample_due & ~reset_pin_in;

  // Flag set mask; sets override the clear-on-read
  wire [7:0] cause_set = {1'b0, ext_rst | late_pin_low, wdog_ovf, ill_op,
                          ill_ad, mon_rst, supply_low & running, 1'b0};

  always_comb begin
    cause_next = cause_reg;
    if (cause_read) begin
      cause_next = 8'h00;
    end
    cause_next = cause_next | cause_set;
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    count_next = count_reg + 13'h0001;
    case (state_reg)
      ST_RUN: begin
        count_next = 13'h0000;
        if (supply_low) begin
          state_next = ST_LOWSUP;
        end else if (internal_rst) begin
          state_next = ST_DRIVE;
        end else if (ext_rst) begin
          state_next = ST_HOLD;
        end
      end
      ST_LOWSUP: begin
        count_next = 13'h0000;
        if (!supply_low) begin
          state_next = ST_STAB;
        end
      end
      ST_STAB: begin
        if (supply_low) begin
          state_next = ST_LOWSUP;
          count_next = 13'h0000;
        end else if (count_reg == 13'(STAB_CYCLES - 1)) begin
          state_next = ST_DRIVE;
          count_next = 13'h0000;
        end
      end
      ST_DRIVE: begin
        if (count_reg == 13'(rst_seq_pkg::PIN_DRIVE_CYC - 1)) begin
          state_next = ST_HOLD;
          count_next = 13'h0000;
        end
      end
      ST_HOLD: begin
        if (count_reg == 13'(rst_seq_pkg::CORE_HOLD_CYC - 1)) begin
          state_next = ST_RUN;
          count_next = 13'h0000;
        end
      end
      default: begin
        state_next = ST_HOLD;
        count_next = 13'h0000;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= ST_STAB;
      count_reg <= 13'h0000;
      cause_reg <= rst_seq_pkg::CAUSE_RESET;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      cause_reg <= cause_next;
    end
  end

  // Pin filter, late sample counter and watchdog
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pulse_reg  <= 8'h00;
      sample_reg <= 6'h00;
      wdog_reg   <= '0;
    end else begin
      if (reset_pin_in | ~running) begin
        pulse_reg <= 8'h00;
      end else if (pulse_reg != 8'hFF) begin
        pulse_reg <= pulse_reg + 8'h01;
      end
      if (pin_released) begin
        sample_reg <= 6'h01;
      end else if (sample_reg != 6'h00 && !sample_due) begin
        sample_reg <= sample_reg + 6'h01;
      end else begin
        sample_reg <= 6'h00;
      end
      if (!running || wdog_write) begin
        wdog_reg <= '0;
      end else begin
        wdog_reg <= wdog_reg + 1'b1;
      end
    end
  end

  // Control register and APB answer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control_reg <= rst_seq_pkg::CONTROL_RESET;
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      if (ctrl_write) begin
        control_reg <= pwdata[7:0];
      end
      pready_reg  <= psel & ~penable;
      prdata_reg  <= rd_mux;
      pslverr_reg <= psel & ~penable & (~mapped | (pwrite & ~hit_ctrl));
    end
  end

  // Interrupt entry
  logic       any_pend;
  logic [4:0] winner;
  wire [N_IRQ-1:0] pend_vec = {irq_requests[N_IRQ-1:1],
                               irq_requests[0] | ext_irq_reg};
  irq_arbiter #(.N(N_IRQ)) arb (
    .pending     (pend_vec),
    .any_pending (any_pend),
    .winner      (winner)
  );
  wire can_take  = running & insn_done & ~latched_reg;
  wire take_swi  = can_take & swi_request;
  wire take_irq  = can_take & ~swi_request & ~mask_reg & any_pend;
  wire [15:0] irq_vec = rst_seq_pkg::IRQ_VECTOR_TOP -
                        {10'h000, winner, 1'b0};
  wire take_any  = take_swi | take_irq;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_irq_reg     <= 1'b0;
      prev_pin_reg    <= 1'b1;
      latched_reg     <= 1'b0;
      latched_vec_reg <= 16'h0000;
      mask_reg        <= 1'b1;
      push_reg        <= 1'b0;
      pop_reg         <= 1'b0;
      ack_reg         <= 1'b0;
    end else begin
      prev_pin_reg <= external_interrupt_pin;
      if (prev_pin_reg & ~external_interrupt_pin) begin
        ext_irq_reg <= 1'b1;
      end else if (take_irq && winner == 5'h00) begin
        ext_irq_reg <= 1'b0;
      end
      if (!running) begin
        latched_reg <= 1'b0;
        mask_reg    <= 1'b1;
      end else if (take_any) begin
        latched_reg     <= 1'b1;
        latched_vec_reg <= take_swi ? rst_seq_pkg::SWI_VECTOR : irq_vec;
      end else if (latched_reg) begin
        latched_reg <= 1'b0;
        mask_reg    <= 1'b1;
      end else if (rti_done) begin
        mask_reg    <= 1'b0;
      end
      push_reg <= running & take_any;
      pop_reg  <= running & rti_done;
      ack_reg  <= running & latched_reg;
    end
  end

  // Registered outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_drive_reg  <= 1'b1;
      core_reset_reg <= 1'b1;
      gated_reg      <= 1'b1;
      vfetch_reg     <= 1'b0;
      vaddr_reg      <= rst_seq_pkg::RESET_VECTOR;
    end else begin
      pin_drive_reg  <= state_next inside {ST_LOWSUP, ST_STAB, ST_DRIVE};
      core_reset_reg <= state_next != ST_RUN;
      gated_reg      <= state_next inside {ST_LOWSUP, ST_STAB};
      vfetch_reg     <= (~running & (state_next == ST_RUN)) |
                        (running & latched_reg);
      vaddr_reg      <= running ? latched_vec_reg :
                                  rst_seq_pkg::RESET_VECTOR;
    end
  end

  assign pready         = pready_reg;
  assign prdata         = prdata_reg;
  assign pslverr        = pslverr_reg;
  assign reset_pin_out  = 1'b0;
  assign reset_pin_oe_n = ~pin_drive_reg;
  assign core_reset     = core_reset_reg;
  assign clocks_gated   = gated_reg;
  assign bus_clock_div  = rst_seq_pkg::BUS_DIV;
  assign vector_fetch   = vfetch_reg;
  assign vector_addr    = vaddr_reg;
  assign stack_push     = push_reg;
  assign stack_pop      = pop_reg;
  assign irq_mask       = mask_reg;
  assign irq_ack        = ack_reg;

  a_read_clear: assert property (@(posedge clock) disable iff (reset)
    cause_read && cause_set == 8'h00 |=> cause_reg == 8'h00)
    else $error("cause not cleared by read");
  a_flag_accum: assert property (@(posedge clock) disable iff (reset)
    !cause_read |=> (cause_reg & $past(cause_reg)) == $past(cause_reg))
    else $error("cause flag lost");
  a_set_wins: assert property (@(posedge clock) disable iff (reset)
    cause_read && |cause_set |=> (~cause_reg & $past(cause_set)) == 8'h00)
    else $error("set lost to read");
  a_drive_len: assert property (@(posedge clock) disable iff (reset)
    running && internal_rst && !supply_low |=> !reset_pin_oe_n [*8])
    else $error("pin not driven");
  a_hold_after: assert property (@(posedge clock) disable iff (reset)
    $rose(reset_pin_oe_n) |-> core_reset [*8])
    else $error("core released early");
  a_mask_swi: assert property (@(posedge clock) disable iff (reset)
    mask_reg && !swi_request |-> !take_any)
    else $error("masked interrupt taken");
  a_no_preempt: assert property (@(posedge clock) disable iff (reset)
    latched_reg |=> $stable(latched_vec_reg) || !running)
    else $error("latched interrupt preempted");
  a_boundary: assert property (@(posedge clock) disable iff (reset)
    take_any |-> insn_done)
    else $error("interrupt mid instruction");
  a_entry_mask: assert property (@(posedge clock) disable iff (reset)
    running && take_any ##1 running |=> mask_reg && stack_push == 1'b0)
    else $error("mask not set on entry");
  a_ill_op: assert property (@(posedge clock) disable iff (reset)
    running && opcode_fetch && opcode_stop && !stop_enabled |=> !running)
    else $error("stop not treated illegal");
endmodule
`default_nettype wire

// ==== dv/reset_line_partner.sv ====
// Outside device sharing the open-drain reset wire, with pull-up
`timescale 1ns/1ps
`default_nettype none
module reset_line_partner (
  input  wire logic clock,
  input  wire logic pull_req,
  input  wire logic dev_oe_n,
  input  wire logic dev_out,
  output logic      wire_level
);
  logic pull_reg;

  always_ff @(posedge clock) begin
    pull_reg <= pull_req;
  end

  // Wire is low if either party pulls, else held high by the pull-up
  assign wire_level = !pull_reg && (dev_oe_n || dev_out);
endmodule
`default_nettype wire

// ==== dv/reset_sequencer_and_irq_entry_tb_top.sv ====
// Self-checking bench for the reset sequencer and interrupt entry
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_and_irq_entry_tb_top;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        reset_wire, reset_pin_out, reset_pin_oe_n, pull_req;
  logic        supply_low, monitor_entry, opcode_fetch, fetch_unmapped;
  logic        opcode_undefined, opcode_stop, wdog_write, insn_done;
  logic        swi_request, rti_done, external_interrupt_pin, irq_mask;
  logic        core_reset, clocks_gated, vector_fetch, stack_push;
  logic        stack_pop, irq_ack, seen_ack, seen_push, seen_pop, kick;
  logic [15:0] irq_requests, vector_addr, seen_vec;
  logic [1:0]  bus_clock_div;
  int          errors, cmp_count;

  reset_sequencer_and_irq_entry #(.STAB_CYCLES(64), .WDOG_W(10))
    i_reset_sequencer_and_irq_entry (
    .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .reset_pin_in(reset_wire), .reset_pin_out,
    .reset_pin_oe_n, .supply_low, .monitor_entry, .opcode_fetch,
    .fetch_addr(16'h0000), .fetch_unmapped, .opcode_undefined,
    .opcode_stop, .wdog_write, .insn_done, .swi_request, .rti_done,
    .external_interrupt_pin, .irq_requests, .core_reset, .clocks_gated,
    .bus_clock_div, .vector_fetch, .vector_addr, .stack_push, .stack_pop,
    .irq_mask, .irq_ack);

  reset_line_partner i_reset_line_partner (
    .clock, .pull_req, .dev_oe_n(reset_pin_oe_n), .dev_out(reset_pin_out),
    .wire_level(reset_wire));

  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    chk(pready, 1'b1, "ready");
    if (!w) chk(prdata, x, "read data");
    chk(pslverr, e, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Measures pin drive and core hold of one reset sequence
  task automatic seq(input int pin_exp, input int hold_exp);
    int n, m;
    n = 0;
    m = 0;
    while (reset_pin_oe_n !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (reset_pin_oe_n === 1'b0 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    while (core_reset === 1'b1 && m < 200) begin
      @(posedge clock);
      m++;
    end
    if (pin_exp > 0) chk(n, pin_exp, "pin drive");
    chk(m, hold_exp, "core hold");
    m = 0;
    while (vector_fetch !== 1'b1 && m < 20) begin
      @(posedge clock);
      m++;
    end
    chk(vector_fetch, 1'b1, "vector fetch");
    chk(vector_addr, 16'hFFFE, "reset vector");
    chk(bus_clock_div, rst_seq_pkg::BUS_DIV, "bus div");
    chk(clocks_gated, 1'b0, "gated after");
  endtask

  task automatic fetch(input logic f, input logic u, input logic s,
                       input logic m);
    opcode_fetch <= f;
    opcode_undefined <= u;
    opcode_stop <= s;
    fetch_unmapped <= m;
    @(posedge clock);
    opcode_fetch <= 1'b0;
    opcode_undefined <= 1'b0;
    opcode_stop <= 1'b0;
    fetch_unmapped <= 1'b0;
    @(posedge clock);
  endtask

  task automatic tick;
    @(posedge clock);
    if (irq_ack === 1'b1) begin
      seen_ack = 1'b1;
      seen_vec = vector_addr;
    end
    seen_push = seen_push | (stack_push === 1'b1);
    seen_pop = seen_pop | (stack_pop === 1'b1);
  endtask

  // Optional return, then an optional instruction boundary, then watch entry
  task automatic op(input logic r, input logic d, input logic s,
                    input logic [15:0] v, input logic hit);
    int n;
    seen_ack = 1'b0;
    seen_push = 1'b0;
    seen_pop = 1'b0;
    seen_vec = 16'h0000;
    rti_done <= r;
    tick;
    rti_done <= 1'b0;
    insn_done <= d;
    swi_request <= s;
    tick;
    insn_done <= 1'b0;
    swi_request <= 1'b0;
    for (n = 0; n < 8; n++) tick;
    chk(seen_ack, hit, "ack");
    chk(seen_push, hit, "push");
    chk(seen_pop, r, "pop");
    if (hit) chk(seen_vec, v, "vector");
    if (hit) chk(irq_mask, 1'b1, "mask set");
    else if (r) chk(irq_mask, 1'b0, "mask clear");
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    $display("[FAIL] %0t timeout", $time);
    stop_test;
  end

  // Keeps the watchdog from expiring while kick is set
  initial begin
    forever begin
      repeat (500) @(posedge clock);
      wdog_write <= kick;
      @(posedge clock);
      wdog_write <= 1'b0;
    end
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pull_req = 1'b0;
    supply_low = 1'b0;
    monitor_entry = 1'b0;
    opcode_fetch = 1'b0;
    fetch_unmapped = 1'b0;
    opcode_undefined = 1'b0;
    opcode_stop = 1'b0;
    wdog_write = 1'b0;
    insn_done = 1'b0;
    swi_request = 1'b0;
    rti_done = 1'b0;
    external_interrupt_pin = 1'b1;
    irq_requests = 16'h0000;
    errors = 0;
    cmp_count = 0;
    kick = 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    chk(clocks_gated, 1'b1, "gated");
    seq(0, 32);
    apb(0, 12'h000, 32'h0000_0000, 32'h0000_0080, 1'b0);
    apb(1, 12'h000, 32'h0000_00FF, 0, 1'b1);
    apb(0, 12'h000, 32'h0000_0000, 0, 1'b0);
    apb(1, 12'h00C, 32'h0000_0000, 0, 1'b1);
    apb(1, 12'h008, 32'h0000_0001, 0, 1'b0);
    fetch(1'b1, 1'b0, 1'b1, 1'b0);
    fetch(1'b0, 1'b0, 1'b0, 1'b1);
    repeat (40) @(posedge clock);
    chk(core_reset, 1'b0, "no reset");
    apb(1, 12'h008, 32'h0000_0000, 0, 1'b0);
    fetch(1'b1, 1'b0, 1'b1, 1'b0);
    seq(32, 32);
    fetch(1'b1, 1'b0, 1'b0, 1'b1);
    seq(32, 32);
    fetch(1'b1, 1'b1, 1'b0, 1'b0);
    seq(32, 32);
    apb(0, 12'h000, 32'h0000_0000, 32'h0000_0018, 1'b0);
    pull_req <= 1'b1;
    repeat (8) @(posedge clock);
    pull_req <= 1'b0;
    repeat (4) @(posedge clock);
    chk(core_reset, 1'b1, "pin reset");
    repeat (100) @(posedge clock);
    apb(0, 12'h000, 32'h0000_0000, 32'h0000_0040, 1'b0);
    pull_req <= 1'b1;
    monitor_entry <= 1'b1;
    @(posedge clock);
    monitor_entry <= 1'b0;
    // Wire let go just after the late sample, too soon for a pin reset
    repeat (64) @(posedge clock);
    pull_req <= 1'b0;
    repeat (120) @(posedge clock);
    apb(0, 12'h000, 32'h0000_0000, 32'h0000_0044, 1'b0);
    supply_low <= 1'b1;
    repeat (20) @(posedge clock);
    chk(reset_pin_oe_n, 1'b0, "pin low");
    chk(reset_pin_out, 1'b0, "pin level");
    chk(clocks_gated, 1'b1, "gated low supply");
    supply_low <= 1'b0;
    seq(0, 32);
    apb(0, 12'h000, 32'h0000_0000, 32'h0000_0002, 1'b0);
    op(1'b1, 1'b1, 1'b0, 16'h0000, 1'b0);
    irq_requests <= 16'h0028;
    op(1'b0, 1'b0, 1'b0, 16'h0000, 1'b0);
    op(1'b0, 1'b1, 1'b0, 16'hFFF4, 1'b1);
    irq_requests <= 16'h0020;
    op(1'b0, 1'b1, 1'b0, 16'h0000, 1'b0);
    op(1'b0, 1'b1, 1'b1, 16'hFFFC, 1'b1);
    op(1'b1, 1'b1, 1'b0, 16'hFFF0, 1'b1);
    irq_requests <= 16'h0000;
    op(1'b1, 1'b1, 1'b0, 16'h0000, 1'b0);
    external_interrupt_pin <= 1'b0;
    @(posedge clock);
    external_interrupt_pin <= 1'b1;
    op(1'b0, 1'b1, 1'b0, 16'hFFFA, 1'b1);
    // Watchdog left to expire
    kick = 1'b0;
    while (reset_pin_oe_n !== 1'b0) @(posedge clock);
    seq(32, 32);
    kick = 1'b1;
    apb(0, 12'h000, 32'h0000_0000, 32'h0000_0020, 1'b0);
    // Illegal opcode lands on the access edge of a flag read
    fork
      apb(0, 12'h000, 32'h0000_0000, 32'h0000_0000, 1'b0);
      begin
        @(posedge clock);
        fetch(1'b1, 1'b1, 1'b0, 1'b0);
      end
    join
    seq(32, 32);
    apb(0, 12'h000, 32'h0000_0000, 32'h0000_0010, 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire
